// file: hw/scgc_pkg.sv
// scgc_pkg: constants and carrier types of the system clock generator control
package scgc_pkg;
  // register byte offsets, one aligned 32-bit word each, data in bits 15:0
  localparam logic [7:0] OFS_GEN_CTL1 = 8'h00;
  localparam logic [7:0] OFS_GEN_MULT = 8'h04;
  localparam logic [7:0] OFS_GEN_RDIV = 8'h08;
  localparam logic [7:0] OFS_GEN_ODIV = 8'h0C;
  localparam logic [7:0] OFS_CLK_CFG2 = 8'h10;
  localparam logic [7:0] OFS_PER_GATE1 = 8'h14;
  localparam logic [7:0] OFS_CPU_GATE = 8'h18;
  localparam logic [7:0] OFS_USB_OSC = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // field positions beyond bit 0
  localparam int F_RD_BYPASS = 15;
  localparam int F_OD_ENABLE = 15;
  localparam int F_DOMAIN = 1;
  // reset values
  localparam logic RST_PLL_PD = 1'b1;
  localparam logic RST_MODE = 1'b0;
  localparam logic RST_USB_EN = 1'b0;
  localparam logic [7:0] RST_DOM_OFF = 8'h00;
  // offsets added to the ratio fields
  localparam logic [12:0] MULT_BASE = 13'h0004;
  localparam logic [12:0] RDIV_BASE = 13'h0004;
  localparam logic [12:0] ODIV_BASE = 13'h0001;
  // bypass hold time after a ratio change or power-up, 40 MHz clock
  localparam int LOCK_TIME_US = 4000;
  localparam int CLK_KHZ = 40000;
  localparam int LOCK_CYC = (LOCK_TIME_US * CLK_KHZ) / 1000;
  // rtc register window in i/o space
  localparam logic [15:0] RTC_WIN_LO = 16'h1900;
  localparam logic [15:0] RTC_WIN_HI = 16'h197F;
  // edges after reset release before the strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // pin bit positions inside scgc_pins_t
  localparam int PIN_EXT = 0;
  localparam int PIN_RTC = 1;
  localparam int PIN_VCO = 2;
  localparam int PIN_STRAP = 3;
  localparam int PIN_RTCOK = 4;
  localparam int PIN_WAKE = 5;
  localparam int PIN_EXTERNAL_INTERRUPT_ZERO = 6;
  localparam int PIN_EXTERNAL_INTERRUPT_ONE = 7;
  localparam int PIN_RTCIRQ = 8;
  typedef enum logic [3:0] {
    SW_BYP = 4'b0001,
    SW_TOP = 4'b0010,
    SW_PLL = 4'b0100,
    SW_TOB = 4'b1000
  } scgc_sw_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } scgc_avs_req_t;
  typedef struct packed {
    logic rtc_irq;
    logic external_interrupt_one;
    logic external_interrupt_zero;
    logic wakeup;
    logic rtc_osc_ok;
    logic ref_strap;
    logic pll_vco;
    logic rtc_clk;
    logic external_reference_input;
  } scgc_pins_t;
endpackage : scgc_pkg

// file: hw/scgc_top.sv
// scgc_top: system clock generator control, clock mux and top-level gating
// Behaviour
// [RQ1] reference is the external input or rtc oscillator, chosen by strap level
// [RQ2] board holds the reference strap fixed after reset release
// [RQ3] generator can be fully bypassed, reference forwarded as system clock
// [RQ4] usb oscillator can never become the system reference
// [RQ5] usb oscillator stays off after reset until software enables it
// [RQ6] rtc off means rtc idle and its i/o window not serviced
// [RQ7] writing one to pll_power_down stops the pll
// [RQ8] software selects bypass before powering the pll down
// [RQ9] failsafe refuses pll mode while the pll is powered down
// [RQ10] software keeps bypass for the whole pll power-down time
// [RQ11] master_clock_stop stops the main clock to cpu and peripherals
// [RQ12] wakeup, either external interrupt or rtc interrupt restarts it
// [RQ13] cpu_idle_gate gates the cpu clock once the cpu executes idle
// [RQ14] any unmasked interrupt restores the gated cpu clock
// [RQ15] bypass mode drives the system clock at the reference frequency
// [RQ16] pll mode clock is the multiplied and divided reference
// [RQ17] bypass and pll switching is glitch-free, no short pulses
// [RQ18] clock domains each have a software gate, re-enabled by software
// [RQ19] gated peripheral read returns last value or stalls
// [RQ20] reset sets pll_power_down and clears pll_mode_select
// [RQ21] software keeps bypass four ms after ratio changes before pll mode
// [RQ22] pll clock follows reference times (m+4), divided by ratios
// [RQ23] every gate enable changes only while its clock is low
`timescale 1ns/10ps
`default_nettype none
module scgc_top #(
  parameter int unsigned LOCK_CYCLES = scgc_pkg::LOCK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire scgc_pkg::scgc_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire scgc_pkg::scgc_pins_t pins_i,
  input wire logic cpu_idle_i,
  input wire logic cpu_irq_i,
  input wire logic io_req_i,
  input wire logic [15:0] io_addr_i,
  output logic main_system_clock_o,
  output logic cpu_clock_o,
  output logic [7:0] domain_clock_o,
  output logic pll_power_down_o,
  output logic pll_reference_clock_o,
  output logic [12:0] pll_multiplier_o,
  output logic usb_osc_enable_o,
  output logic rtc_enable_o,
  output logic rtc_select_o
);
  import scgc_pkg::*;

  // whole state of the block, registered in one place
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic ref_sel_rtc;
    logic pll_pd;
    logic mode;
    logic [11:0] mult;
    logic [11:0] rdr;
    logic rdbyp;
    logic [6:0] odr;
    logic oden;
    logic stop;
    logic [7:0] dom_off;
    logic idle_gate;
    logic usb_en;
    logic cpu_gated;
    scgc_sw_t st;
    logic mux;
    logic ref_prev;
    logic vco_prev;
    logic [12:0] rcnt;
    logic [12:0] ocnt;
    logic rclk;
    logic [12:0] pll_mul;
    logic m_en;
    logic c_en;
    logic [7:0] d_en;
    logic sys;
    logic cpu_clk;
    logic [7:0] dom_clk;
    logic [17:0] lock_cnt;
    logic settled;
    logic wreq;
    logic [31:0] rdata;
    logic rtc_run;
    logic rtc_sel;
  } scgc_state_t;

  scgc_state_t q;
  scgc_state_t d;
  logic req_any;
  logic want;
  logic bsrc;
  logic vco;
  logic psrc;
  logic wake_any;
  logic relock;
  logic [12:0] rd_n;
  logic [12:0] od_n;
  logic [15:0] cur;
  logic [15:0] wv;

  // next count of an edge divider, wraps to zero at the divisor
  function automatic logic [12:0] div_next(input logic [12:0] cnt, input logic [12:0] n);
    div_next = ((cnt + 13'h0001) >= n) ? 13'h0000 : cnt + 13'h0001;
  endfunction : div_next

  // only the two low byte lanes carry register bits
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wdat,
                                           input logic [3:0] be);
    be_merge = old;
    if (be[0]) be_merge[7:0] = wdat[7:0];
    if (be[1]) be_merge[15:8] = wdat[15:8];
  endfunction : be_merge

  // all next-state logic
  always_comb begin
    d = q;
    relock = 1'b0;
    req_any = avs_req_i.read | avs_req_i.write;
    // pins pass two flops; only s2 is ever looked at
    d.s1 = pins_i;
    d.s2 = q.s1;
    // strap caught once it has crossed both flops
    if (q.strap_cnt < STRAP_SETTLE) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
    end else if (!q.strap_done) begin
      d.ref_sel_rtc = q.s2[PIN_STRAP]; // [RQ1]
      d.strap_done = 1'b1;
    end
    // only external and rtc references exist, the usb oscillator has no path here
    bsrc = q.ref_sel_rtc ? q.s2[PIN_RTC] : q.s2[PIN_EXT]; // [RQ1] [RQ4]
    vco = q.s2[PIN_VCO];
    want = q.mode & ~q.pll_pd; // [RQ9]
    wake_any = q.s2[PIN_WAKE] | q.s2[PIN_EXTERNAL_INTERRUPT_ZERO] | q.s2[PIN_EXTERNAL_INTERRUPT_ONE] | q.s2[PIN_RTCIRQ];

    // register read view, also the base for byte-lane merging
    case (avs_req_i.address)
      OFS_GEN_CTL1: cur = {15'h0000, q.pll_pd};
      OFS_GEN_MULT: cur = {4'h0, q.mult};
      OFS_GEN_RDIV: cur = {q.rdbyp, 3'h0, q.rdr};
      OFS_GEN_ODIV: cur = {q.oden, 8'h00, q.odr};
      OFS_CLK_CFG2: cur = {15'h0000, q.mode};
      OFS_PER_GATE1: cur = {7'h00, q.dom_off, q.stop};
      OFS_CPU_GATE: cur = {15'h0000, q.idle_gate};
      OFS_USB_OSC: cur = {15'h0000, q.usb_en};
      OFS_STATUS: cur = {9'h000, q.settled, q.s2[PIN_RTCOK], q.cpu_gated, q.stop,
                         q.ref_sel_rtc, q.strap_done, q.st == SW_PLL};
      default: cur = 16'h0000;
    endcase
    wv = be_merge(cur, avs_req_i.writedata, avs_req_i.byteenable);

    // one wait state: data is prepared in the first cycle, write lands in the second
    d.wreq = 1'b1;
    if (req_any && q.wreq) begin
      d.wreq = 1'b0;
      if (avs_req_i.read) d.rdata = {16'h0000, cur};
    end
    if (req_any && !q.wreq && avs_req_i.write) begin
      case (avs_req_i.address)
        OFS_GEN_CTL1: d.pll_pd = wv[0]; // [RQ7]
        OFS_GEN_MULT: begin
          d.mult = wv[11:0];
          relock = 1'b1;
        end
        OFS_GEN_RDIV: begin
          d.rdr = wv[11:0];
          d.rdbyp = wv[F_RD_BYPASS];
          relock = 1'b1;
        end
        OFS_GEN_ODIV: begin
          d.odr = wv[6:0];
          d.oden = wv[F_OD_ENABLE];
          relock = 1'b1;
        end
        OFS_CLK_CFG2: d.mode = wv[0];
        OFS_PER_GATE1: begin
          d.stop = wv[0]; // [RQ11]
          d.dom_off = wv[F_DOMAIN +: 8]; // [RQ18]
        end
        OFS_CPU_GATE: d.idle_gate = wv[0];
        OFS_USB_OSC: d.usb_en = wv[0]; // [RQ5]
        default: ;
      endcase
    end

    // pins wake the stopped master clock with no cpu help; wins over a write
    if (q.stop && wake_any) d.stop = 1'b0; // [RQ12]
    // an interrupt wins over a new idle so a wake is never lost
    if (cpu_irq_i) begin
      d.cpu_gated = 1'b0; // [RQ14]
    end else if (cpu_idle_i && q.idle_gate) begin
      d.cpu_gated = 1'b1; // [RQ13]
    end

    // reference divider on reference edges, bypassable
    rd_n = 13'(q.rdr) + RDIV_BASE;
    if (bsrc && !q.ref_prev) d.rcnt = div_next(q.rcnt, rd_n); // [RQ22]
    d.ref_prev = bsrc;
    d.rclk = q.rdbyp ? bsrc : (q.rcnt < (rd_n >> 1)); // [RQ22]
    d.pll_mul = 13'(q.mult) + MULT_BASE; // [RQ16] [RQ22]
    // output divider on pll edges; odd divisors give a non-50% duty cycle
    od_n = 13'(q.odr) + ODIV_BASE;
    if (vco && !q.vco_prev) d.ocnt = div_next(q.ocnt, od_n); // [RQ22]
    d.vco_prev = vco;
    psrc = (q.oden && (od_n != ODIV_BASE)) ? (q.ocnt < (od_n >> 1)) : vco; // [RQ16]

    // lock timer only reports; the switch itself is left to software
    if (q.pll_pd || relock) begin
      d.lock_cnt = 18'h00000;
      d.settled = 1'b0;
    end else if (q.lock_cnt >= 18'(LOCK_CYCLES)) begin
      d.settled = 1'b1; // [RQ21]
    end else begin
      d.lock_cnt = q.lock_cnt + 18'h00001;
    end

    // glitch-free mux: leave a source only while it is low, hold low, join the other low
    case (q.st)
      SW_BYP: begin
        d.mux = bsrc; // [RQ3] [RQ15]
        if (want && !bsrc) begin
          d.st = SW_TOP; // [RQ17]
          d.mux = 1'b0;
        end
      end
      SW_TOP: begin
        d.mux = 1'b0;
        if (!want && !bsrc) d.st = SW_BYP; // [RQ9]
        else if (want && !psrc) d.st = SW_PLL; // [RQ17]
      end
      SW_PLL: begin
        d.mux = psrc; // [RQ16]
        if (!want && !psrc) begin
          d.st = SW_TOB; // [RQ17]
          d.mux = 1'b0;
        end
      end
      SW_TOB: begin
        d.mux = 1'b0;
        if (!bsrc) d.st = SW_BYP; // [RQ17]
      end
      default: begin
        d.mux = 1'b0;
        d.st = SW_BYP;
      end
    endcase

    // gate enables move only while the muxed clock is low, so no pulse is cut
    if (!q.mux) begin
      d.m_en = ~q.stop; // [RQ23] [RQ11]
      d.c_en = ~q.cpu_gated; // [RQ23] [RQ13]
      d.d_en = ~q.dom_off; // [RQ23] [RQ18]
    end
    d.sys = q.mux & q.m_en;
    d.cpu_clk = q.mux & q.m_en & q.c_en;
    // a gated domain sees its clock held low, so its registers keep the last value
    d.dom_clk = {8{q.mux & q.m_en}} & q.d_en; // [RQ19]

    // rtc runs and its window answers only with the oscillator present
    d.rtc_run = q.s2[PIN_RTCOK]; // [RQ6]
    d.rtc_sel = io_req_i && (io_addr_i >= RTC_WIN_LO) && (io_addr_i <= RTC_WIN_HI)
                && q.s2[PIN_RTCOK]; // [RQ6]
  end

  // single state register, synchronous reset to constants
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.pll_pd <= RST_PLL_PD; // [RQ20]
      q.mode <= RST_MODE; // [RQ20]
      q.usb_en <= RST_USB_EN; // [RQ5]
      q.dom_off <= RST_DOM_OFF;
      q.st <= SW_BYP;
      q.wreq <= 1'b1;
      q.pll_mul <= MULT_BASE;
    end else begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wreq;
  assign main_system_clock_o = q.sys;
  assign cpu_clock_o = q.cpu_clk;
  assign domain_clock_o = q.dom_clk;
  assign pll_power_down_o = q.pll_pd;
  assign pll_reference_clock_o = q.rclk;
  assign pll_multiplier_o = q.pll_mul;
  assign usb_osc_enable_o = q.usb_en;
  assign rtc_enable_o = q.rtc_run;
  assign rtc_select_o = q.rtc_sel;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_enter_pll;
    $rose(q.st == SW_PLL);
  endsequence
  sequence s_bus_first;
    (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o;
  endsequence

  property p_reset_state;
    $rose(rst_n_i) |-> pll_power_down_o && !usb_osc_enable_o && q.st == SW_BYP && !q.mode;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state"); // [RQ20]

  property p_failsafe;
    s_enter_pll |-> $past(want) && !$past(q.pll_pd);
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("pll taken while down"); // [RQ9]

  property p_glitch_free;
    $changed(q.st) |-> !q.mux ##1 (q.st != SW_TOP && q.st != SW_TOB) || !q.mux;
  endproperty
  a_glitch_free: assert property (p_glitch_free) else $error("switch not low"); // [RQ17]

  property p_bypass_follow;
    (q.st == SW_BYP && $past(q.st) == SW_BYP) |-> q.mux == $past(bsrc);
  endproperty
  a_bypass_follow: assert property (p_bypass_follow) else $error("bypass lost"); // [RQ15]

  property p_master_stop;
    !q.m_en |=> !main_system_clock_o && !cpu_clock_o;
  endproperty
  a_master_stop: assert property (p_master_stop) else $error("clock ran"); // [RQ11]

  property p_wake;
    q.stop && wake_any |=> !q.stop ##[1:3] !q.mux || q.m_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // [RQ12]

  property p_idle_gate;
    cpu_idle_i && q.idle_gate && !cpu_irq_i |=> q.cpu_gated;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle not gated"); // [RQ13]

  property p_irq_wake;
    q.cpu_gated && cpu_irq_i |=> !q.cpu_gated;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq lost"); // [RQ14]

  property p_enable_sync;
    $changed(q.m_en) || $changed(q.c_en) |-> !$past(q.mux);
  endproperty
  a_enable_sync: assert property (p_enable_sync) else $error("gate moved high"); // [RQ23]

  property p_rtc_window;
    rtc_select_o |-> $past(q.s2[PIN_RTCOK]) && $past(io_req_i);
  endproperty
  a_rtc_window: assert property (p_rtc_window) else $error("rtc served off"); // [RQ6]

  property p_bus_answer;
    s_bus_first |=> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
endmodule : scgc_top
`default_nettype wire

// file: testbench/scgc_cpu_model.sv
// scgc_cpu_model: cpu core and peripherals fed by the generated clocks
`timescale 1ns/10ps
`default_nettype none
module scgc_cpu_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cpu_clock_i,
  input wire logic main_clock_i,
  input wire logic [7:0] domain_clock_i,
  input wire logic idle_cmd_i,
  input wire logic irq_cmd_i,
  input wire logic dom_clr_i,
  output logic cpu_idle_o,
  output logic cpu_irq_o,
  output int unsigned cpu_rises_o,
  output int unsigned main_rises_o,
  output logic [7:0] dom_seen_o
);
  logic cpu_q;
  logic main_q;
  // count delivered rising edges; only levels reach this side
  always @(posedge sys_clk_i) begin
    cpu_q <= cpu_clock_i;
    main_q <= main_clock_i;
    cpu_idle_o <= idle_cmd_i;
    cpu_irq_o <= irq_cmd_i;
    if (!rst_n_i) begin
      cpu_rises_o <= 0;
      main_rises_o <= 0;
    end else begin
      cpu_rises_o <= cpu_rises_o + 32'(cpu_clock_i & !cpu_q);
      main_rises_o <= main_rises_o + 32'(main_clock_i & !main_q);
    end
    // per-domain activity, cleared on request
    dom_seen_o <= dom_clr_i ? 8'h00 : (dom_seen_o | domain_clock_i);
  end
endmodule : scgc_cpu_model
`default_nettype wire

// file: testbench/system_clock_generator_control_bench.sv
// system_clock_generator_control_bench: self-checking bench of scgc_top
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module system_clock_generator_control_bench;
  import scgc_pkg::*;
  localparam int LOCK = 16;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  scgc_avs_req_t req = '0;
  scgc_pins_t pins;
  logic ext = 1'b0, rtc_clk = 1'b0, vco = 1'b0, strap = 1'b0, rtc_ok = 1'b0;
  logic [3:0] wake = 4'h0;
  logic idle_cmd = 1'b0, irq_cmd = 1'b0, dom_clr = 1'b0, io_req = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic cpu_idle, cpu_irq, main_clk, cpu_clk, pd, pref, usb, rtc_en, rtc_sel, waitreq;
  logic [31:0] rdata, r;
  logic [7:0] dom, seen;
  logic [12:0] mult;
  int unsigned cpu_n, main_n, m, c, cnt = 0, pref_n = 0, pa;
  logic pref_q = 1'b0;
  int n_mismatch = 0, n_checks = 0;
  int mdl[int];
  assign pins = {wake, rtc_ok, strap, vco, rtc_clk, ext};
  // reference toggles every 3 cycles, rtc every 5, pll output every cycle
  always @(posedge sys_clk_i) begin
    cnt <= cnt + 1;
    vco <= ~vco;
    if (cnt % 3 == 0) ext <= ~ext;
    if (cnt % 5 == 0) rtc_clk <= ~rtc_clk;
  end
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // rising edges of the pll reference output; unknown levels before reset never count
  always @(posedge sys_clk_i) begin
    pref_q <= pref;
    if (pref === 1'b1 && pref_q === 1'b0) pref_n <= pref_n + 1;
  end
  scgc_top #(.LOCK_CYCLES(LOCK)) u_scgc_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .pins_i(pins),
    .cpu_idle_i(cpu_idle), .cpu_irq_i(cpu_irq), .io_req_i(io_req), .io_addr_i(io_addr),
    .main_system_clock_o(main_clk), .cpu_clock_o(cpu_clk), .domain_clock_o(dom),
    .pll_power_down_o(pd), .pll_reference_clock_o(pref), .pll_multiplier_o(mult),
    .usb_osc_enable_o(usb), .rtc_enable_o(rtc_en), .rtc_select_o(rtc_sel));
  scgc_cpu_model u_scgc_cpu_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cpu_clock_i(cpu_clk), .main_clock_i(main_clk), .domain_clock_i(dom),
    .idle_cmd_i(idle_cmd), .irq_cmd_i(irq_cmd), .dom_clr_i(dom_clr), .cpu_idle_o(cpu_idle),
    .cpu_irq_o(cpu_irq), .cpu_rises_o(cpu_n), .main_rises_o(main_n), .dom_seen_o(seen));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    req <= '{address: a, read: !w, write: w, writedata: wd, byteenable: 4'hF};
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    r = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (k >= 50) `CHK("waitrequest", 1'b0, waitreq)
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    mdl[a] = d;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask);
    bus(1'b0, a, 32'h0);
    `CHK("register", 32'(mdl[a]) & mask, r & mask)
  endtask : rd_chk
  // rising edges of the main and cpu clocks over 60 cycles
  task automatic meas();
    int unsigned a, b;
    a = main_n;
    b = cpu_n;
    repeat (60) @(posedge sys_clk_i);
    m = main_n - a;
    c = cpu_n - b;
  endtask : meas
  task automatic do_reset(input logic s);
    rst_n_i <= 1'b0;
    strap <= s;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    mdl.delete();
    mdl[OFS_GEN_CTL1] = 1;
    mdl[OFS_CLK_CFG2] = 0;
    mdl[OFS_USB_OSC] = 0;
    mdl[8'h40] = 0;
    repeat (4) @(posedge sys_clk_i);
  endtask : do_reset
  task automatic wake_test(input int i);
    wr(OFS_PER_GATE1, 32'h1);
    repeat (6) @(posedge sys_clk_i);
    meas();
    `CHK("stopped main", 0, m)
    wake[i] <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    wake[i] <= 1'b0;
    mdl[OFS_PER_GATE1] = 0;
    repeat (6) @(posedge sys_clk_i);
    meas();
    `CHK("woken main", 1'b1, m >= 9 && m <= 11)
    rd_chk(OFS_PER_GATE1, 32'h1);
  endtask : wake_test
  // watchdog sized well above the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    $display("[ERR] watchdog expired");
    stop_test();
  end
  initial begin
    void'($urandom(32'h9665));
    do_reset(1'b0);
    foreach (mdl[a]) rd_chk(8'(a), 32'hFFFF);
    `CHK("power down pin", 1'b1, pd)
    `CHK("usb pin", 1'b0, usb)
    mdl[OFS_GEN_MULT] = $urandom & 32'hFFF;
    wr(OFS_GEN_MULT, mdl[OFS_GEN_MULT]);
    rd_chk(OFS_GEN_MULT, 32'hFFF);
    `CHK("multiplier", 13'(mdl[OFS_GEN_MULT]) + MULT_BASE, mult)
    $display("test registers done");
    meas();
    `CHK("bypass external", 1'b1, m >= 9 && m <= 11)
    // reference period 6 cycles, divider 0+4 gives one pll reference edge per 24 cycles
    pa = pref_n;
    repeat (96) @(posedge sys_clk_i);
    `CHK("reference divider", 1'b1, (pref_n - pa) >= 3 && (pref_n - pa) <= 5)
    wr(OFS_CLK_CFG2, 32'h1);
    repeat (10) @(posedge sys_clk_i);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("pll refused", 1'b0, r[0])
    wr(OFS_CLK_CFG2, 32'h0);
    wr(OFS_GEN_CTL1, 32'h0);
    repeat (LOCK + 4) @(posedge sys_clk_i);
    `CHK("power up pin", 1'b0, pd)
    wr(OFS_CLK_CFG2, 32'h1);
    repeat (10) @(posedge sys_clk_i);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("pll selected", 1'b1, r[0])
    meas();
    `CHK("pll clock", 1'b1, m >= 20)
    wr(OFS_CLK_CFG2, 32'h0);
    repeat (10) @(posedge sys_clk_i);
    wr(OFS_GEN_CTL1, 32'h1);
    meas();
    `CHK("back to bypass", 1'b1, m >= 9 && m <= 11)
    `CHK("power down pin", 1'b1, pd)
    $display("test pll switching done");
    for (int i = 0; i < 4; i++) wake_test(i);
    $display("test master stop done");
    mdl[0] = $urandom_range(1, 255);
    for (int p = 0; p < 2; p++) begin
      wr(OFS_PER_GATE1, p == 0 ? 32'(mdl[0]) << 1 : 32'h0);
      dom_clr <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      dom_clr <= 1'b0;
      repeat (60) @(posedge sys_clk_i);
      `CHK("domain clocks", p == 0 ? ~8'(mdl[0]) : 8'hFF, seen)
    end
    $display("test domain gates done");
    for (int g = 0; g < 2; g++) begin
      wr(OFS_CPU_GATE, 32'(g));
      idle_cmd <= 1'b1;
      @(posedge sys_clk_i);
      idle_cmd <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      meas();
      `CHK("cpu clock idle", g == 0, c >= 9 && c <= 11)
      `CHK("main during idle", 1'b1, m >= 9 && m <= 11)
    end
    irq_cmd <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    irq_cmd <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    meas();
    `CHK("cpu clock woken", 1'b1, c >= 9 && c <= 11)
    $display("test cpu idle done");
    for (int k = 0; k < 8; k++) begin
      rtc_ok <= k[2];
      io_addr <= k[1] ? (k[0] ? 16'h1980 : 16'h18FF) : (k[0] ? RTC_WIN_HI : RTC_WIN_LO);
      repeat (5) @(posedge sys_clk_i);
      io_req <= 1'b1;
      @(posedge sys_clk_i);
      io_req <= 1'b0;
      @(posedge sys_clk_i);
      `CHK("rtc select", k[2] & !k[1], rtc_sel)
      `CHK("rtc enable", k[2], rtc_en)
    end
    wr(OFS_USB_OSC, 32'h1);
    @(posedge sys_clk_i);
    `CHK("usb enable", 1'b1, usb)
    $display("test rtc window and usb done");
    do_reset(1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("rtc reference", 1'b1, r[2])
    meas();
    `CHK("bypass rtc", 1'b1, m >= 5 && m <= 7)
    $display("test rtc reference done");
    stop_test();
  end
endmodule : system_clock_generator_control_bench
`default_nettype wire
